// >>> rtl/burst_sram_ctrl.sv
// control and address input stage of a pipelined burst sram
module burst_sram_ctrl
  import burst_sram_pkg::*;
#(
  parameter int AW = ADDR_WIDTH,
  parameter int LANES = LANE_COUNT
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // synchronous control pins
  input wire logic [AW-1:0] i_addr,
  input wire logic [LANES-1:0] i_byte_lane_write_select_n,
  input wire logic i_write_strobe_n,
  input wire logic i_advance_or_load,
  input wire logic i_clock_qualify_n,
  input wire logic i_chip_select_first_n,
  input wire logic i_chip_select_second,
  input wire logic i_chip_select_third_n,
  input wire logic i_burst_order_interleaved,
  // captured access stream toward the array
  output logic o_acc_valid,
  output logic o_acc_write,
  output logic [AW-1:0] o_acc_addr,
  output logic [LANES-1:0] o_acc_lane_we,
  input wire logic i_acc_ready,
  // state visible to the data path
  output logic o_selected,
  output logic o_input_stall
);
  localparam int ENTRY_W = AW + LANES + 1;

  // burst sequence step: interleaved xors the count, linear adds it
  function automatic logic [BURST_BITS-1:0] burst_step(
    input logic [BURST_BITS-1:0] start,
    input logic [BURST_BITS-1:0] cnt,
    input logic interleaved
  );
    burst_step = interleaved ? (start ^ cnt) : (start + cnt);
  endfunction : burst_step

  logic [AW-1:0] base_addr_r;
  logic [BURST_BITS-1:0] burst_cnt_r;
  logic [BURST_BITS-1:0] burst_cnt_nxt;
  logic [AW-1:0] base_addr_nxt;
  logic selected_r;
  logic order_r;
  access_type kind_r;
  access_type kind_nxt;
  logic buf_ready;
  logic buf_valid;
  logic [ENTRY_W-1:0] buf_data;
  logic [ENTRY_W-1:0] entry;
  logic acc_valid_r;
  logic acc_write_r;
  logic [AW-1:0] acc_addr_r;
  logic [LANES-1:0] acc_lane_we_r;
  logic stall_r;

  // a clock edge counts only when qualify is low and the buffer can take a word
  wire edge_ok = !i_clock_qualify_n && buf_ready;
  wire chip_sel = !i_chip_select_first_n
    && i_chip_select_second
    && !i_chip_select_third_n;
  wire do_load = !i_advance_or_load;
  // advancing while deselected has nothing to advance; treated as idle
  wire do_adv = i_advance_or_load && selected_r;
  wire is_write = !i_write_strobe_n;
  wire [LANES-1:0] lane_we = is_write ? ~i_byte_lane_write_select_n : '0;
  wire [AW-1:0] out_addr = {base_addr_nxt[AW-1:BURST_BITS],
    burst_step(base_addr_nxt[BURST_BITS-1:0], burst_cnt_nxt, order_r)};

  // next command state from the pins
  always_comb begin
    base_addr_nxt = base_addr_r;
    burst_cnt_nxt = burst_cnt_r;
    kind_nxt = ACC_IDLE;
    if (do_load) begin
      if (chip_sel) begin
        base_addr_nxt = i_addr;
        burst_cnt_nxt = BURST_START_RST;
        kind_nxt = is_write ? ACC_WRITE : ACC_READ;
      end
    end else if (do_adv) begin
      burst_cnt_nxt = burst_cnt_r + 2'h1;
      kind_nxt = kind_r;
    end
  end

  // packed entry: write flag, lane enables, word address
  assign entry = {kind_nxt == ACC_WRITE, lane_we, out_addr};
  wire push = edge_ok && (kind_nxt != ACC_IDLE);

  // command state only moves on a qualified edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      base_addr_r <= ADDR_RST;
      burst_cnt_r <= BURST_START_RST;
      kind_r <= ACC_IDLE;
      selected_r <= 1'b0;
    end else if (edge_ok) begin
      base_addr_r <= base_addr_nxt;
      burst_cnt_r <= burst_cnt_nxt;
      kind_r <= kind_nxt;
      if (do_load) begin
        selected_r <= chip_sel;
      end
    end
  end

  // strap is a static level; sampled after reset rather than at it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      order_r <= 1'b1;
    end else begin
      order_r <= i_burst_order_interleaved;
    end
  end

  pair_buffer #(
    .WIDTH(ENTRY_W)
  ) u_buf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(push),
    .i_data(entry),
    .o_ready(buf_ready),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(!acc_valid_r || i_acc_ready)
  );

  // output register stage; the access word follows one edge after capture
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_valid_r <= 1'b0;
      acc_write_r <= 1'b0;
      acc_addr_r <= ADDR_RST;
      acc_lane_we_r <= '0;
      stall_r <= 1'b0;
    end else begin
      stall_r <= !buf_ready;
      if (!acc_valid_r || i_acc_ready) begin
        acc_valid_r <= buf_valid;
        acc_write_r <= buf_data[ENTRY_W-1];
        acc_lane_we_r <= buf_data[AW +: LANES];
        acc_addr_r <= buf_data[AW-1:0];
      end
    end
  end

  assign o_acc_valid = acc_valid_r;
  assign o_acc_write = acc_write_r;
  assign o_acc_addr = acc_addr_r;
  assign o_acc_lane_we = acc_lane_we_r;
  assign o_selected = selected_r;
  assign o_input_stall = stall_r;
endmodule : burst_sram_ctrl

// >>> rtl/burst_sram_pkg.sv
// package: constants for the pipelined burst sram control input block
package burst_sram_pkg;
  localparam int ADDR_WIDTH = 18;
  localparam int LOCATION_COUNT = 266144;
  localparam int LANE_COUNT = 4;
  localparam int LANE_WIDTH = 9;
  localparam int DATA_WIDTH = LANE_COUNT * LANE_WIDTH;
  localparam int BURST_BITS = 2;
  localparam logic [BURST_BITS-1:0] BURST_START_RST = 2'h0;
  localparam logic [ADDR_WIDTH-1:0] ADDR_RST = 18'h00000;
  localparam int BUF_DEPTH = 2;
  // access kind carried with each captured command
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_READ = 3'b010,
    ACC_WRITE = 3'b100
  } access_type;
endpackage : burst_sram_pkg

// >>> rtl/pair_buffer.sv
// two-entry valid/ready buffer for captured access words
module pair_buffer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  logic [WIDTH-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  wire push = i_valid && (count_r != 2'h2);
  wire pop = i_ready && (count_r != 2'h0);

  // pointer and occupancy bookkeeping
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wr_ptr_r] <= i_data;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // ready is registered from occupancy so it never loops through the drain side
  assign o_ready = (count_r != 2'h2);
  assign o_valid = (count_r != 2'h0);
  assign o_data = mem_r[rd_ptr_r];
endmodule : pair_buffer

// >>> tb/burst_sram_ctrl_bench.sv
// self-checking bench for the burst sram control input stage
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module burst_sram_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst = 1, i_acc_ready = 0, i_burst_order_interleaved = 1;
  logic i_write_strobe_n, i_advance_or_load, i_clock_qualify_n, o_acc_valid, o_acc_write;
  logic i_chip_select_first_n, i_chip_select_second, i_chip_select_third_n, o_selected;
  logic o_input_stall;
  logic [17:0] i_addr, o_acc_addr;
  logic [3:0] i_byte_lane_write_select_n, o_acc_lane_we;
  logic [22:0] q[$], g;
  int num_errors = 0, n_checks = 0, n;
  burst_sram_ctrl u_dut (.*);
  sram_ctrl_partner u_ctl (.i_clk, .o_addr(i_addr), .o_lane_n(i_byte_lane_write_select_n),
    .o_write_n(i_write_strobe_n), .o_adv(i_advance_or_load), .o_qual_n(i_clock_qualify_n),
    .o_cs({i_chip_select_first_n, i_chip_select_second, i_chip_select_third_n}));
  initial forever #2 i_clk = ~i_clk;
  // accepted words queue up in arrival order
  always @(posedge i_clk) if (o_acc_valid && i_acc_ready) q.push_back({o_acc_write, o_acc_lane_we, o_acc_addr});
  task pop(input logic [22:0] e);
    g = q.size() ? q.pop_front() : 'x;
    `CHK("word", e, g)
  endtask : pop
  // linear then interleaved bursts of five words, the second with ignored edges between
  task t_burst;
    for (int m = 0; m < 2; m++) begin
      i_burst_order_interleaved <= m[0];
      i_acc_ready <= 1'b1;
      u_ctl.idle(2);
      u_ctl.cmd(0, 18'h2A5B5, 0, 4'hA, 3'h2);
      repeat (4) begin u_ctl.cmd(1, 18'h0, 0, 4'hA, 3'h2); u_ctl.idle(m); end
      u_ctl.idle(6);
      for (int k = 0; k < 5; k++) pop({5'h15, 16'hA96D, m ? 2'(1 ^ k) : 2'(1 + k)});
    end
    $display("burst test done");
  endtask : t_burst
  // read with lanes low, then each chip select dropped in turn; advances after a deselect are wasted
  task t_select;
    for (int i = 0; i < 4; i++) begin
      u_ctl.cmd(0, 18'h10, 1, 4'h0, 3'(12'h583 >> (9 - 3 * i)));
      u_ctl.cmd(1, 18'h0, 1, 4'h0, 3'h2);
    end
    u_ctl.idle(6);
    pop({5'h0, 18'h10});
    pop({5'h0, 18'h11});
    `CHK("left", 0, q.size())
    `CHK("sel", 1'b0, o_selected)
    $display("select test done");
  endtask : t_select
  // fill the buffer with the drain stalled, then drain it
  task t_stall;
    i_acc_ready <= 1'b0;
    n = 0;
    repeat (6) begin
      #1;
      if (!o_input_stall) begin u_ctl.cmd(0, 18'(256 + n), 1, 4'hF, 3'h2); n++; end
      u_ctl.idle(2);
    end
    #1;
    `CHK("stall", 1'b1, o_input_stall)
    `CHK("fill", 1'b1, 1'(n > 1 && n < 6))
    // ready changes on the rising edge like every other input
    @(posedge i_clk);
    i_acc_ready <= 1'b1;
    u_ctl.idle(8);
    for (int i = 0; i < n; i++) pop({5'h0, 18'(256 + i)});
    $display("stall test done");
  endtask : t_stall
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    t_burst;
    t_select;
    t_stall;
    end_of_test;
  end
  // the tests need well under a thousand cycles
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
endmodule : burst_sram_ctrl_bench

// >>> tb/sram_ctrl_monitor.sv
// checker for the burst sram control input stage
module sram_ctrl_monitor #(parameter int AW = 18, parameter int LANES = 4) (
  input wire logic i_clk, i_rst, i_write_strobe_n, i_advance_or_load, i_clock_qualify_n,
  input wire logic i_chip_select_first_n, i_chip_select_second, i_chip_select_third_n,
  input wire logic o_acc_valid, o_acc_write, i_acc_ready, o_selected, o_input_stall,
  input wire logic [AW-1:0] i_addr, o_acc_addr,
  input wire logic [LANES-1:0] i_byte_lane_write_select_n, o_acc_lane_we
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // a request is taken on a qualified edge while the buffer has room
  wire go = !i_clock_qualify_n && !o_input_stall;
  wire ld = go && !i_advance_or_load;
  wire sel = !i_chip_select_first_n && i_chip_select_second && !i_chip_select_third_n;
  wire tk = ld && sel || go && i_advance_or_load && o_selected;
  // latency is exact only when no older word can slip in ahead
  word_hold_a: assert property (o_acc_valid && !i_acc_ready |=> $stable(o_acc_addr))
    else $error("word changed");
  read_lanes_a: assert property (o_acc_valid && !o_acc_write |-> !o_acc_lane_we)
    else $error("lane on read");
  qual_hold_a: assert property (i_clock_qualify_n |=> $stable(o_selected))
    else $error("edge not ignored");
  sel_on_a: assert property (ld && sel && !o_acc_valid |=> o_selected)
    else $error("not selected");
  sel_off_a: assert property (ld && !sel && !o_acc_valid |=> !o_selected)
    else $error("not deselected");
  wr_lanes_a: assert property (tk && ld && !i_write_strobe_n && !o_acc_valid && !$past(tk)
    |-> ##2 o_acc_write && o_acc_lane_we == ~$past(i_byte_lane_write_select_n, 2))
    else $error("bad lanes");
  load_word_a: assert property (tk && ld && !o_acc_valid && !$past(tk)
    |-> ##2 o_acc_valid && o_acc_addr == $past(i_addr, 2) && o_acc_write == !$past(i_write_strobe_n, 2))
    else $error("bad word");
  adv_idle_a: assert property (go && i_advance_or_load && !o_selected && !o_acc_valid
    && !$past(tk) |-> ##2 !o_acc_valid)
    else $error("advance unselected");
endmodule : sram_ctrl_monitor
bind burst_sram_ctrl sram_ctrl_monitor #(.AW(AW), .LANES(LANES)) u_mon (.*);

// >>> tb/sram_ctrl_partner.sv
// controller model that drives the synchronous control pins
module sram_ctrl_partner (
  input wire logic i_clk,
  output logic [17:0] o_addr,
  output logic [3:0] o_lane_n,
  output logic o_write_n, o_adv, o_qual_n,
  output logic [2:0] o_cs
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_qual_n, o_adv, o_write_n, o_addr, o_lane_n, o_cs} = {1'b1, 27'h0};
  // one qualified edge carrying a load or an advance
  task cmd(input logic v, input logic [17:0] a, input logic w, input logic [3:0] l,
           input logic [2:0] c);
    @(posedge i_clk);
    o_qual_n <= 1'b0;
    {o_adv, o_addr, o_write_n, o_lane_n, o_cs} <= {v, a, w, l, c};
  endtask : cmd
  // unqualified edges: pins wander so a wrongly honoured edge shows
  task idle(input int k);
    repeat (k) begin
      @(posedge i_clk);
      o_qual_n <= 1'b1;
      {o_adv, o_addr, o_write_n, o_cs} <= ~{o_adv, o_addr, o_write_n, o_cs};
    end
  endtask : idle
endmodule : sram_ctrl_partner
